//--- bcpa_pkg.sv
// Purpose: constants and state type for the capture/accumulator block
// Assumes: 32-bit APB data, one word per register
// Notes: all control state resets to zero
package bcpa_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_TCTL = 8'h00;
    localparam logic [7:0] OFS_FSEL = 8'h04;
    localparam logic [7:0] OFS_PROT = 8'h08;
    localparam logic [7:0] OFS_SYS = 8'h0c;
    localparam logic [7:0] OFS_EDGE = 8'h10;
    localparam logic [7:0] OFS_MDCTL = 8'h14;
    localparam logic [7:0] OFS_MDCNT = 8'h18;
    localparam logic [7:0] OFS_TCNT = 8'h1c;
    localparam logic [7:0] OFS_CAP = 8'h20;
    localparam logic [7:0] OFS_HOLD = 8'h40;
    localparam logic [7:0] OFS_ACC = 8'h50;
    localparam logic [7:0] OFS_ACCH = 8'h60;
    localparam logic [7:0] OFS_OCC = 8'h70;
    // field positions
    localparam int TC_EN = 0;
    localparam int TC_PRE = 8;
    localparam int SYS_LATCH_QUEUE_SELECT = 0;
    localparam int SYS_SAT = 1;
    localparam int SYS_CASC = 2;
    localparam int SYS_DSEL = 4;
    localparam int MD_EN = 0;
    localparam int MD_PER = 1;
    localparam int MD_FLAT = 2;
    localparam int MD_PRE = 4;
    // input qualification delays
    localparam int CLK_NS = 40;
    localparam int DLY1_NS = 160;
    localparam int DLY2_NS = 640;
    localparam int DLY3_NS = 2560;
    localparam logic [7:0] DLY1_CYC = 8'((DLY1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] DLY2_CYC = 8'((DLY2_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] DLY3_CYC = 8'((DLY3_NS + CLK_NS - 1) / CLK_NS);

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] filt;
        logic [7:0][7:0] dcnt;
        logic ten;
        logic [6:0] tpre;
        logic [6:0] tpc;
        logic [15:0] tcnt;
        logic [7:0] fsel;
        logic [7:0] prot;
        logic [15:0] edge_sel;
        logic latch_queue_select;
        logic sat;
        logic [1:0] casc;
        logic [1:0] dsel;
        logic md_en;
        logic md_per;
        logic [3:0] md_pre;
        logic [3:0] md_pc;
        logic [15:0] md_mod;
        logic [15:0] md_cnt;
        logic md_zero;
        logic [7:0][15:0] cap;
        logic [7:0] capf;
        logic [3:0][15:0] hold;
        logic [3:0] holdf;
        logic [3:0][7:0] acc;
        logic [3:0][7:0] acch;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } bcpa_state_s;

    // reset value of the whole state
    localparam bcpa_state_s BCPA_RST_STATE = '0;
endpackage : bcpa_pkg

//--- bcpa_top.sv
// Purpose: buffered capture channels, pulse accumulators, modulus timebase
// Assumes: pins asynchronous to pclk, APB master with no byte strobes
// Notes: channels 0-3 are the buffered ones
// Operation
// - 16-bit up timer with prescaler
// - eight channels, capture when selected
// - channels 0-3 also have holding registers
// - capture empty after read or latch
// - holding occupied from load until read
// - unbuffered capture, protect keeps full value
// - latch mode copies capture to holding
// - unprotected latch mode always overwrites
// - protect writes only empty registers
// - unprotected queue mode shifts capture into holding
// - queue holding read latches accumulator
// - four 8-bit accumulators with holding
// - saturate bit stops count at max
// - pairs cascade into 16-bit accumulators
// - in latch mode, latch events move and clear accumulators
// - 16-bit down counter, 4-bit prescaler
// - down counter latches periodic or once
// - main prescaler seven bits wide
// - selectable delays reject short pulses
// - function bit 0 capture, 1 compare
`timescale 1ns/10ps
`default_nettype none
module bcpa_top
    import bcpa_pkg::*;
#(
    parameter int CH_COUNT = 8,
    parameter int BUF_COUNT = 4,
    parameter int TPRE_WIDTH = 7,
    parameter int MDPRE_WIDTH = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] capture_pin_in,
    output logic modulus_zero_pulse
);

    bcpa_state_s r;
    bcpa_state_s n;
    logic xfer;
    logic wr;
    logic rd;
    logic latch_ev;
    logic [7:0] edge_v;
    logic [3:0] qx;
    logic [7:0] dly;
    logic [31:0] rdata;
    logic err;
    logic [15:0] pair;
    logic [15:0] pair_n;

    // the packed state fixes these sizes, so any other value is refused
    if (CH_COUNT != 8 || BUF_COUNT != 4 ||
        TPRE_WIDTH != 7 || MDPRE_WIDTH != 4) begin : g_size_check
        $error("bcpa_top: unsupported channel, buffer or prescaler size");
    end

    // delay count for a qualification select code
    function automatic logic [7:0] dly_of(input logic [1:0] sel);
        unique case (sel)
            2'h0: dly_of = 8'h00;
            2'h1: dly_of = DLY1_CYC;
            2'h2: dly_of = DLY2_CYC;
            2'h3: dly_of = DLY3_CYC;
        endcase
    endfunction : dly_of

    // one 8-bit accumulator step, optional saturation
    function automatic logic [7:0] step8(input logic [7:0] v, input logic inc,
                                         input logic sat);
        if (inc && !(sat && v == 8'hff)) begin
            step8 = v + 8'h01;
        end else begin
            step8 = v;
        end
    endfunction : step8

    // next-state logic
    always_comb begin
        n = r;
        n.pready = 1'b0;
        n.md_zero = 1'b0;
        n.pslverr = 1'b0; // error flag lasts one cycle, like ready
        latch_ev = 1'b0;
        qx = 4'h0;
        rdata = 32'h0000_0000;
        err = 1'b0;
        pair = 16'h0000;
        pair_n = 16'h0000;
        // ready high blocks a second take while the master still holds access
        xfer = psel & penable & ~r.pready;
        wr = xfer & pwrite;
        rd = xfer & ~pwrite;

        // two-flop synchronisers on the pins
        n.s1 = capture_pin_in;
        n.s2 = r.s1;

        // pulse qualification: level must hold for the selected delay
        // a glitch shorter than the delay never reaches the edge detector
        dly = dly_of(r.dsel);
        for (int c = 0; c < CH_COUNT; c++) begin
            if (r.s2[c] == r.filt[c]) begin
                n.dcnt[c] = 8'h00;
            end else if (r.dcnt[c] >= dly) begin
                n.filt[c] = r.s2[c];
                n.dcnt[c] = 8'h00;
            end else begin
                n.dcnt[c] = r.dcnt[c] + 8'h01;
            end
        end

        // edge detect, capture channels only
        for (int c = 0; c < CH_COUNT; c++) begin
            edge_v[c] = (n.filt[c] ^ r.filt[c]) & ~r.fsel[c] &
                ((n.filt[c] & r.edge_sel[2*c]) | (~n.filt[c] & r.edge_sel[2*c+1]));
        end

        // main timer with 7-bit prescaler
        if (r.ten) begin
            if (r.tpc == r.tpre) begin
                n.tpc = 7'h00;
                n.tcnt = r.tcnt + 16'h0001;
            end else begin
                n.tpc = r.tpc + 7'h01;
            end
        end

        // modulus down-counter with 4-bit prescaler
        if (r.md_en) begin
            if (r.md_pc == r.md_pre) begin
                n.md_pc = 4'h0;
                if (r.md_cnt == 16'h0000) begin
                    if (r.md_per) begin
                        n.md_cnt = r.md_mod;
                    end
                end else begin
                    n.md_cnt = r.md_cnt - 16'h0001;
                    if (r.md_cnt == 16'h0001) begin
                        latch_ev = 1'b1;
                        n.md_zero = 1'b1;
                    end
                end
            end else begin
                n.md_pc = r.md_pc + 4'h1;
            end
        end

        // register writes
        if (wr) begin
            unique case (paddr)
                OFS_TCTL: begin
                    n.ten = pwdata[TC_EN];
                    n.tpre = pwdata[TC_PRE +: 7];
                end
                OFS_FSEL: n.fsel = pwdata[7:0];
                OFS_PROT: n.prot = pwdata[7:0];
                OFS_SYS: begin
                    n.latch_queue_select = pwdata[SYS_LATCH_QUEUE_SELECT];
                    n.sat = pwdata[SYS_SAT];
                    n.casc = pwdata[SYS_CASC +: 2];
                    n.dsel = pwdata[SYS_DSEL +: 2];
                end
                OFS_EDGE: n.edge_sel = pwdata[15:0];
                OFS_MDCTL: begin
                    n.md_en = pwdata[MD_EN];
                    n.md_per = pwdata[MD_PER];
                    n.md_pre = pwdata[MD_PRE +: 4];
                    if (pwdata[MD_FLAT]) begin
                        latch_ev = 1'b1;
                    end
                end
                OFS_MDCNT: begin
                    n.md_mod = pwdata[15:0];
                    n.md_cnt = pwdata[15:0];
                    n.md_pc = 4'h0;
                    if (pwdata[15:0] == 16'h0000) begin
                        latch_ev = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // read mux and read side effects
        if (paddr[1:0] != 2'b00) begin
            err = 1'b1;
        end else if (paddr[7:5] == OFS_CAP[7:5]) begin
            rdata = {16'h0000, r.cap[paddr[4:2]]};
            if (rd) begin
                n.capf[paddr[4:2]] = 1'b0;
            end
        end else if (paddr[7:4] == OFS_HOLD[7:4]) begin
            rdata = {16'h0000, r.hold[paddr[3:2]]};
            if (rd) begin
                n.holdf[paddr[3:2]] = 1'b0;
                qx[paddr[3:2]] = ~r.latch_queue_select;
            end
        end else if (paddr[7:4] == OFS_ACC[7:4]) begin
            rdata = {24'h000000, r.acc[paddr[3:2]]};
        end else if (paddr[7:4] == OFS_ACCH[7:4]) begin
            rdata = {24'h000000, r.acch[paddr[3:2]]};
        end else begin
            unique case (paddr)
                OFS_TCTL: rdata = {17'h00000, r.tpre, 7'h00, r.ten};
                OFS_FSEL: rdata = {24'h000000, r.fsel};
                OFS_PROT: rdata = {24'h000000, r.prot};
                OFS_SYS: rdata = {26'h0000000, r.dsel, r.casc, r.sat, r.latch_queue_select};
                OFS_EDGE: rdata = {16'h0000, r.edge_sel};
                OFS_MDCTL: rdata = {24'h000000, r.md_pre, 2'b00, r.md_per, r.md_en};
                OFS_MDCNT: rdata = {16'h0000, r.md_cnt};
                OFS_TCNT: rdata = {16'h0000, r.tcnt};
                OFS_OCC: rdata = {20'h00000, r.holdf, r.capf};
                default: err = 1'b1;
            endcase
        end

        // latch events copy capture into holding
        // latch events are ignored in queue mode, capture order rules there
        if (latch_ev && r.latch_queue_select) begin
            for (int c = 0; c < BUF_COUNT; c++) begin
                if (!r.prot[c]) begin
                    n.hold[c] = r.cap[c];
                    n.holdf[c] = 1'b1;
                    n.capf[c] = 1'b0;
                end else if (n.capf[c] && !n.holdf[c]) begin
                    n.hold[c] = r.cap[c];
                    n.holdf[c] = 1'b1;
                    n.capf[c] = 1'b0;
                end
            end
        end

        // captures: a new load wins over a same-cycle read
        // reading n.capf keeps a same-cycle read or latch visible here
        for (int c = 0; c < CH_COUNT; c++) begin
            if (edge_v[c]) begin
                if (c < BUF_COUNT && !r.latch_queue_select) begin
                    if (!r.prot[c]) begin
                        if (n.capf[c]) begin
                            n.hold[c] = n.cap[c];
                            n.holdf[c] = 1'b1;
                        end
                        n.cap[c] = r.tcnt;
                        n.capf[c] = 1'b1;
                    end else if (!n.capf[c]) begin
                        n.cap[c] = r.tcnt;
                        n.capf[c] = 1'b1;
                    end
                end else if (!r.prot[c] || !n.capf[c]) begin
                    n.cap[c] = r.tcnt;
                    n.capf[c] = 1'b1;
                end
            end
        end

        // accumulators: transfer and clear, then count
        // an edge in the transfer cycle lands in the cleared counter
        for (int c = 0; c < BUF_COUNT; c++) begin
            if (qx[c] || (latch_ev && r.latch_queue_select)) begin
                n.acch[c] = r.acc[c];
                n.acc[c] = 8'h00;
            end
        end
        for (int p = 0; p < 2; p++) begin
            if (r.casc[p]) begin
                pair = {n.acc[2*p+1], n.acc[2*p]};
                pair_n = pair;
                if (edge_v[2*p] && !(r.sat && pair == 16'hffff)) begin
                    pair_n = pair + 16'h0001;
                end
                n.acc[2*p] = pair_n[7:0];
                n.acc[2*p+1] = pair_n[15:8];
            end else begin
                n.acc[2*p] = step8(n.acc[2*p], edge_v[2*p], r.sat);
                n.acc[2*p+1] = step8(n.acc[2*p+1], edge_v[2*p+1], r.sat);
            end
        end

        // APB answer one cycle into the access phase
        if (xfer) begin
            n.pready = 1'b1;
            n.prdata = pwrite ? 32'h0000_0000 : rdata;
            n.pslverr = err;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= BCPA_RST_STATE;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign modulus_zero_pulse = r.md_zero;

endmodule : bcpa_top
`default_nettype wire

//--- bcpa_assertions.sv
// Purpose: port checks for the capture block
// Assumes: one clock domain
// Notes: bound onto bcpa_top
`timescale 1ns/10ps
`default_nettype none
module bcpa_assertions
    import bcpa_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] capture_pin_in,
    input wire logic modulus_zero_pulse
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // completed read
    wire logic rdd = pready && !pwrite;
    // bus answer timing and read data
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_holds: assert property (!pready |-> $stable(prdata))
        else $error("read data moved");
    a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data after write");
    a_unaligned_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned accepted");
    a_latch_reads_zero: assert property (rdd && paddr == OFS_MDCTL |-> !prdata[MD_FLAT])
        else $error("force latch reads one");
    a_wide_upper: assert property (rdd && paddr inside {[OFS_MDCNT:8'h4c]}
        |-> prdata[31:16] == 16'h0) else $error("wide value too wide");
    a_fsel_upper: assert property (rdd && paddr == OFS_FSEL |-> prdata[31:8] == 24'h0)
        else $error("select wider than eight");
    // main scenarios
    c_hold_read: cover property (rdd && paddr == OFS_HOLD);
    c_zero_pulse: cover property (modulus_zero_pulse);
    c_refused: cover property (pready && pslverr);
endmodule : bcpa_assertions
bind bcpa_top bcpa_assertions u_bcpa_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pin_in(capture_pin_in),
    .modulus_zero_pulse(modulus_zero_pulse));
`default_nettype wire

//--- bcpa_pins.sv
// Purpose: outside signal sources on the channel pins
// Assumes: pulse lengths in pclk cycles
// Notes: pins idle low between pulses
`timescale 1ns/10ps
`default_nettype none
module bcpa_pins (
    input wire logic pclk,
    output logic [7:0] capture_pin_in
);
    initial capture_pin_in = 8'h00;
    // n pulses on one pin, w cycles high then w low
    task automatic pulse(input int ch, input int n, input int w);
        repeat (n) begin
            @(posedge pclk);
            capture_pin_in[ch] <= 1'b1;
            repeat (w) @(posedge pclk);
            capture_pin_in[ch] <= 1'b0;
            repeat (w) @(posedge pclk);
        end
    endtask : pulse
endmodule : bcpa_pins
`default_nettype wire

//--- bcpa_tb.sv
// Purpose: self-checking bench for the capture block
// Assumes: one wait state on every transfer
// Notes: random counts and prescales from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module bcpa_tb;
    import bcpa_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, pins;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, mzp, rerr;
    logic [15:0] t0, tm, c;
    int miscompares = 0, checks = 0, cyc = 0, n, m, p, k;
    bcpa_top u_bcpa_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_pin_in(pins), .modulus_zero_pulse(mzp));
    bcpa_pins u_bcpa_pins (.pclk(pclk), .capture_pin_in(pins));
    initial forever #20 pclk = ~pclk;
    // hang limit
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one whole-word transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
            if (i > 20) begin
                miscompares++;
                conclude();
            end
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // timer read, pulse, timer read, pulse
    task automatic two_caps(input int ch);
        apb(0, OFS_TCNT, 0);
        t0 = rdat[15:0];
        u_bcpa_pins.pulse(ch, 1, 4);
        apb(0, OFS_TCNT, 0);
        tm = rdat[15:0];
        u_bcpa_pins.pulse(ch, 1, 4);
    endtask : two_caps
    task automatic wait_zero(output int q);
        q = 0;
        do begin
            @(posedge pclk);
            q++;
        end while (mzp !== 1'b1 && q < 500);
    endtask : wait_zero
    function automatic logic in_span(input logic [15:0] v);
        return v > t0 && v < tm;
    endfunction : in_span
    function automatic logic [31:0] acc_exp(input int e, input int s);
        return (s == 1 && e > 255) ? 32'hff : 32'(e % 256);
    endfunction : acc_exp
    // main sequence
    initial begin
        void'($urandom(83796));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_FSEL, 0);
        check("select reset", rdat, 0);
        apb(0, 8'h02, 0);
        check("unaligned", rerr, 1);
        apb(0, 8'hfc, 0);
        check("unmapped", {rerr, rdat[30:0]}, 32'h80000000);
        apb(1, OFS_TCTL, 1);
        apb(1, OFS_EDGE, 32'h5555);
        for (int pr = 1; pr >= 0; pr--) begin
            apb(1, OFS_PROT, 32'(pr * 16));
            two_caps(4);
            apb(0, OFS_OCC, 0);
            check("ch4 full", rdat[4], 1);
            apb(0, OFS_CAP + 8'h10, 0);
            check("ch4 value", in_span(rdat[15:0]), pr);
            apb(0, OFS_OCC, 0);
            check("ch4 empty", rdat[4], 0);
        end
        two_caps(0);
        apb(0, OFS_CAP, 0);
        check("queue cap", in_span(rdat[15:0]), 0);
        apb(0, OFS_HOLD, 0);
        check("queue hold", in_span(rdat[15:0]), 1);
        apb(0, OFS_ACCH, 0);
        check("queue acc hold", rdat, 2);
        apb(0, OFS_ACC, 0);
        check("queue acc", rdat, 0);
        apb(0, OFS_OCC, 0);
        check("queue hold empty", rdat[8], 0);
        apb(1, OFS_SYS, 1);
        n = $urandom_range(6, 1);
        u_bcpa_pins.pulse(1, n, 4);
        apb(0, OFS_CAP + 8'h04, 0);
        c = rdat[15:0];
        apb(1, OFS_MDCTL, 32'h4);
        apb(0, OFS_HOLD + 8'h04, 0);
        check("latch hold", rdat, c);
        apb(0, OFS_ACCH + 8'h04, 0);
        check("latch acc hold", rdat, n);
        apb(0, OFS_ACC + 8'h04, 0);
        check("latch acc", rdat, 0);
        u_bcpa_pins.pulse(1, 2, 4);
        apb(1, OFS_MDCNT, 0);
        apb(0, OFS_ACCH + 8'h04, 0);
        check("zero write latch", rdat, 2);
        apb(1, OFS_PROT, 32'h2);
        u_bcpa_pins.pulse(1, 1, 4);
        apb(1, OFS_MDCTL, 32'h4);
        apb(0, OFS_OCC, 0);
        check("protected latch", rdat & 32'h202, 32'h202);
        for (int s = 1; s >= 0; s--) begin
            apb(1, OFS_SYS, 32'(1 + 2 * s));
            apb(1, OFS_MDCTL, 32'h4);
            u_bcpa_pins.pulse(2, 257, 2);
            apb(0, OFS_ACC + 8'h08, 0);
            check("acc limit", rdat, acc_exp(257, s));
        end
        apb(1, OFS_SYS, 32'h11);
        apb(1, OFS_FSEL, 32'h40);
        u_bcpa_pins.pulse(5, 1, 2);
        u_bcpa_pins.pulse(6, 1, 8);
        apb(0, OFS_OCC, 0);
        check("short or compare", rdat[6:5], 0);
        u_bcpa_pins.pulse(5, 1, 8);
        apb(0, OFS_OCC, 0);
        check("long pulse", rdat[5], 1);
        apb(1, OFS_SYS, 32'h5);
        apb(1, OFS_MDCTL, 32'h4);
        n = $urandom_range(300, 257);
        u_bcpa_pins.pulse(0, n, 2);
        apb(0, OFS_ACC, 0);
        check("pair low", rdat, n % 256);
        apb(0, OFS_ACC + 8'h04, 0);
        check("pair high", rdat, n / 256);
        m = $urandom_range(9, 2);
        p = $urandom_range(3, 0);
        apb(1, OFS_MDCNT, 32'(m));
        apb(1, OFS_MDCTL, 32'(3 + 16 * p));
        wait_zero(k);
        wait_zero(k);
        check("period", k, (m + 1) * (p + 1));
        apb(1, OFS_MDCTL, 0);
        apb(1, OFS_MDCNT, 32'(m));
        apb(1, OFS_MDCTL, 32'(1 + 16 * p));
        n = 0;
        repeat (3 * (m + 1) * (p + 1)) begin
            @(posedge pclk);
            n += int'(mzp === 1'b1);
        end
        check("one shot", n, 1);
        k = $urandom_range(2, 0);
        apb(1, OFS_TCTL, 32'(1 + 256 * ((1 << k) - 1)));
        apb(0, OFS_TCNT, 0);
        t0 = rdat[15:0];
        apb(0, OFS_TCNT, 0);
        check("prescale", 16'(rdat[15:0] - t0), 4 >> k);
        conclude();
    end
endmodule : bcpa_tb
`default_nettype wire
